// ==== include/chb_pkg.sv ====
package chb_pkg;

    // interface modes
    typedef enum logic [1:0] {
        CHB_MODE_MEM = 2'b00,
        CHB_MODE_IO  = 2'b01,
        CHB_MODE_IDE = 2'b10
    } chb_mode_e;

    // lane selection for one read
    typedef enum logic [1:0] {
        CHB_LANE_NONE = 2'b00,
        CHB_LANE_EVEN = 2'b01,
        CHB_LANE_ODD  = 2'b10,
        CHB_LANE_WORD = 2'b11
    } chb_lane_e;

    // read request taken from the host pins
    typedef struct packed {
        logic            task_file;
        logic            control_block;
        logic [10:0]     addr;
        chb_lane_e       lane;
        chb_mode_e       mode;
    } chb_req_s;

    // read data coming back from the core
    typedef struct packed {
        logic [15:0]     data;
    } chb_rsp_s;

    localparam int        CHB_DATA_W      = 16;
    localparam int        CHB_ADDR_W      = 11;
    localparam int        CHB_BUF_DEPTH   = 2;
    localparam logic      CHB_PIN_HIGH    = 1'b1;
    localparam logic      CHB_PIN_LOW     = 1'b0;
    localparam logic      CHB_OE_DRIVE    = 1'b0;
    localparam logic      CHB_OE_RELEASE  = 1'b1;
    localparam int        CHB_BYTE_LO     = 0;
    localparam int        CHB_BYTE_HI     = 8;
    localparam logic [15:0] CHB_DATA_ZERO = 16'h0000;

endpackage

// ==== design/chb_buffer.sv ====
`timescale 1ns/1ns
// two-entry buffer carrying read data toward the pins
module chb_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_reset,
    // fill side
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    // drain side
    output logic                  o_valid,
    output logic      [WIDTH-1:0] o_data,
    input  wire logic             i_ready
);
    // refuse depths the one-bit pointers cannot serve
    if (DEPTH != 2 || WIDTH < 1) begin : g_bad_depth
        $error("chb_buffer supports depth 2 only");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic             wp_q, wp_d, rp_q, rp_d;
    logic [1:0]       cnt_q, cnt_d;
    logic             push, pop;

    // pointer and count update
    always_comb begin
        push  = i_valid && (cnt_q != 2'(DEPTH));
        pop   = i_ready && (cnt_q != 2'd0);
        mem_d = mem_q;
        if (push) begin
            mem_d[wp_q] = i_data;
        end
        wp_d  = push ? ~wp_q : wp_q;
        rp_d  = pop ? ~rp_q : rp_q;
        cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge i_core_clk) begin
        mem_q <= mem_d;
        if (i_reset) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_ready = (cnt_q != 2'(DEPTH));
    assign o_valid = (cnt_q != 2'd0);
    assign o_data  = mem_q[rp_q];
endmodule

// ==== design/chb_lane_mux.sv ====
`timescale 1ns/1ns
// steers a 16-bit word onto the byte lanes asked for
module chb_lane_mux (
    // selection
    input  wire chb_pkg::chb_lane_e i_lane,
    input  wire logic               i_swap,
    // data
    input  wire logic [15:0]        i_word,
    output logic      [15:0]        o_bus
);
    // bit 0 carries the even byte lsb, bit 8 the odd byte lsb
    always_comb begin
        case (i_lane)
            chb_pkg::CHB_LANE_WORD: o_bus = i_word;
            chb_pkg::CHB_LANE_EVEN: o_bus = {8'h00, i_word[7:0]};
            chb_pkg::CHB_LANE_ODD: begin
                // odd byte on low lane for 8-bit hosts
                o_bus = i_swap ? {8'h00, i_word[15:8]}
                               : {i_word[15:8], 8'h00};
            end
            default: o_bus = chb_pkg::CHB_DATA_ZERO;
        endcase
    end
endmodule

// ==== design/chb_host_port.sv ====
`timescale 1ns/1ns
// Overview of operation
// - memory mode holds the battery-detect-two output high.
// - i/o mode holds the audio output high.
// - ide mode uses the activity/slave-present line as a two-way pin.
// - both card-detect outputs are low in every mode.
// - high enable picks the odd byte, low enable picks by a0 and high.
// - bytes are multiplexed so an 8-bit host sees all on the low lane.
// - in ide the first select gates task file, second the control block.
// - in ide a low cable select means master, open means slave.
// - pc card modes ignore cable select.
// - bit zero is even byte lsb, bit eight is odd byte lsb.
// - ide task file reads use the low lane, data reads all sixteen.
// - input acknowledge goes low only for a selected i/o read.
// - input acknowledge stays idle in memory and ide modes.
// - i/o mode drives read data only while the read strobe is low.
// - ide mode treats the read strobe as in i/o mode.
module chb_host_port (
    // clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset,
    // mode and strap
    input  wire chb_pkg::chb_mode_e     i_mode,
    input  wire logic                   i_cable_select_n,
    // host selects and address
    input  wire logic                   i_low_byte_enable_n,
    input  wire logic                   i_high_byte_enable_n,
    input  wire logic [10:0]            i_addr,
    input  wire logic                   i_io_read_strobe_n,
    // core read port
    output chb_pkg::chb_req_s           o_req,
    output logic                        o_req_valid,
    input  wire chb_pkg::chb_rsp_s      i_rsp,
    input  wire logic                   i_rsp_valid,
    output logic                        o_rsp_ready,
    // data bus pins
    output logic [15:0]                 o_data,
    output logic [15:0]                 o_data_oe_n,
    // status pins
    output logic                        o_battery_detect_two,
    output logic                        o_card_detect_one_n,
    output logic                        o_card_detect_two_n,
    output logic                        o_input_acknowledge_n,
    // activity / slave present pin
    input  wire logic                   i_drive_active_slave_present_n,
    output logic                        o_drive_active_slave_present_n,
    output logic                        o_drive_active_slave_present_oe_n,
    // internal status
    output logic                        o_is_master,
    output logic                        o_peer_present
);
    // i/o mode audio pin shares the battery-detect-two pin

    logic        sel_any, read_act, swap, low_on, high_on;
    chb_pkg::chb_lane_e lane;
    chb_pkg::chb_req_s  req;
    logic        buf_valid, buf_in_ready;
    logic [15:0] buf_data, bus_word;

    // master/slave strap and handshake state
    logic        master_q, master_d;
    logic        peer_q, peer_d;
    logic        rd_q, rd_d;
    logic        busy_q, busy_d;
    logic        strap_done_q, strap_done_d;

    // output flops
    logic [15:0] data_q, data_d;
    logic [15:0] oe_q, oe_d;
    logic        bvd_q, bvd_d;
    logic        ack_q, ack_d;
    logic        pres_q, pres_d;
    logic        pres_oe_q, pres_oe_d;
    chb_pkg::chb_req_s req_q, req_d;
    logic        req_v_q, req_v_d;
    logic [15:0] hold_q, hold_d;

    function automatic chb_pkg::chb_lane_e pick_lane(
        input logic lo_n,
        input logic hi_n,
        input logic a0
    );
        // byte/word decode from the card enables
        if (!lo_n && !hi_n) begin
            pick_lane = chb_pkg::CHB_LANE_WORD;
        end else if (!lo_n) begin
            pick_lane = a0 ? chb_pkg::CHB_LANE_ODD : chb_pkg::CHB_LANE_EVEN;
        end else if (!hi_n) begin
            pick_lane = chb_pkg::CHB_LANE_ODD;
        end else begin
            pick_lane = chb_pkg::CHB_LANE_NONE;
        end
    endfunction

    // selection decode per mode
    always_comb begin
        low_on  = !i_low_byte_enable_n;
        high_on = !i_high_byte_enable_n;
        req     = '0;
        req.mode = i_mode;
        req.addr = i_addr;
        swap    = 1'b0;
        lane    = chb_pkg::CHB_LANE_NONE;
        sel_any = 1'b0;
        case (i_mode)
            chb_pkg::CHB_MODE_IO: begin
                lane    = pick_lane(i_low_byte_enable_n,
                                    i_high_byte_enable_n, i_addr[0]);
                swap    = low_on && !high_on;
                sel_any = low_on || high_on;
            end
            chb_pkg::CHB_MODE_IDE: begin
                req.task_file     = low_on;
                req.control_block = high_on && !low_on;
                lane    = (low_on && i_addr[2:0] == 3'h0)
                          ? chb_pkg::CHB_LANE_WORD
                          : chb_pkg::CHB_LANE_EVEN;
                sel_any = low_on || high_on;
            end
            default: begin
                sel_any = 1'b0; // memory mode reads use another strobe
            end
        endcase
        req.lane = lane;
        read_act = sel_any && !i_io_read_strobe_n;
    end

    chb_lane_mux u_lane_mux (
        .i_lane (req_q.lane),
        .i_swap (swap),
        .i_word (hold_q),
        .o_bus  (bus_word)
    );

    chb_buffer #(
        .WIDTH (chb_pkg::CHB_DATA_W),
        .DEPTH (chb_pkg::CHB_BUF_DEPTH)
    ) u_buffer (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_valid    (i_rsp_valid),
        .i_data     (i_rsp.data),
        .o_ready    (buf_in_ready),
        .o_valid    (buf_valid),
        .o_data     (buf_data),
        .i_ready    (read_act && rd_q)
    );

    // request, strap and pin next state
    always_comb begin
        rd_d    = read_act;
        req_d   = read_act ? req : req_q;
        // one request per strobe, on its falling edge
        req_v_d = read_act && !rd_q;
        hold_d  = (buf_valid && read_act && rd_q) ? buf_data : hold_q;
        busy_d  = read_act;
        // strap caught once after reset, ide only
        strap_done_d = strap_done_q || (i_mode == chb_pkg::CHB_MODE_IDE);
        master_d = master_q;
        if (!strap_done_q && i_mode == chb_pkg::CHB_MODE_IDE) begin
            master_d = !i_cable_select_n;
        end
        // master samples the line only while it has let go
        // so its own activity drive is never taken for a slave
        peer_d = peer_q;
        if (i_mode != chb_pkg::CHB_MODE_IDE || !master_q) begin
            peer_d = 1'b0;
        end else if (pres_oe_q == chb_pkg::CHB_OE_RELEASE) begin
            peer_d = !i_drive_active_slave_present_n;
        end
        pres_d    = chb_pkg::CHB_PIN_LOW;
        pres_oe_d = chb_pkg::CHB_OE_RELEASE;
        if (i_mode == chb_pkg::CHB_MODE_IDE) begin
            // slave announces presence, master shows activity
            pres_oe_d = (master_q && !busy_q) ? chb_pkg::CHB_OE_RELEASE
                                              : chb_pkg::CHB_OE_DRIVE;
        end
        // fixed high in pc card modes
        bvd_d = chb_pkg::CHB_PIN_HIGH;
        if (i_mode == chb_pkg::CHB_MODE_IDE) begin
            bvd_d = pres_d;
        end
        ack_d = !(read_act && i_mode == chb_pkg::CHB_MODE_IO);
        data_d = bus_word;
        oe_d   = {16{chb_pkg::CHB_OE_RELEASE}};
        if (read_act && rd_q) begin
            case (req_q.lane)
                chb_pkg::CHB_LANE_WORD: oe_d = {16{chb_pkg::CHB_OE_DRIVE}};
                chb_pkg::CHB_LANE_EVEN: oe_d = {{8{chb_pkg::CHB_OE_RELEASE}},
                                               {8{chb_pkg::CHB_OE_DRIVE}}};
                chb_pkg::CHB_LANE_ODD: begin
                    oe_d = swap ? {{8{chb_pkg::CHB_OE_RELEASE}},
                                   {8{chb_pkg::CHB_OE_DRIVE}}}
                                : {{8{chb_pkg::CHB_OE_DRIVE}},
                                   {8{chb_pkg::CHB_OE_RELEASE}}};
                end
                default: oe_d = {16{chb_pkg::CHB_OE_RELEASE}};
            endcase
        end
    end

    // register everything
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rd_q         <= 1'b0;
            req_q        <= '0;
            req_v_q      <= 1'b0;
            hold_q       <= chb_pkg::CHB_DATA_ZERO;
            busy_q       <= 1'b0;
            strap_done_q <= 1'b0;
            master_q     <= 1'b0;
            peer_q       <= 1'b0;
            pres_q       <= chb_pkg::CHB_PIN_LOW;
            pres_oe_q    <= chb_pkg::CHB_OE_RELEASE;
            bvd_q        <= chb_pkg::CHB_PIN_HIGH;
            ack_q        <= chb_pkg::CHB_PIN_HIGH;
            data_q       <= chb_pkg::CHB_DATA_ZERO;
            oe_q         <= {16{chb_pkg::CHB_OE_RELEASE}};
        end else begin
            rd_q         <= rd_d;
            req_q        <= req_d;
            req_v_q      <= req_v_d;
            hold_q       <= hold_d;
            busy_q       <= busy_d;
            strap_done_q <= strap_done_d;
            master_q     <= master_d;
            peer_q       <= peer_d;
            pres_q       <= pres_d;
            pres_oe_q    <= pres_oe_d;
            bvd_q        <= bvd_d;
            ack_q        <= ack_d;
            data_q       <= data_d;
            oe_q         <= oe_d;
        end
    end

    // pin and port outputs
    assign o_req                             = req_q;
    assign o_req_valid                       = req_v_q;
    assign o_rsp_ready                       = buf_in_ready;
    assign o_data                            = data_q;
    assign o_data_oe_n                       = oe_q;
    assign o_battery_detect_two              = bvd_q;
    assign o_card_detect_one_n               = chb_pkg::CHB_PIN_LOW;
    assign o_card_detect_two_n               = chb_pkg::CHB_PIN_LOW;
    assign o_input_acknowledge_n             = ack_q;
    assign o_drive_active_slave_present_n    = pres_q;
    assign o_drive_active_slave_present_oe_n = pres_oe_q;
    assign o_is_master                       = master_q;
    assign o_peer_present                    = peer_q;
endmodule

// ==== verif/chb_host_model.sv ====
`timescale 1ns/1ns
// host socket model: drives selects and strobe, samples the data bus
module chb_host_model (
    // pins seen from the card
    input  wire logic        i_core_clk,
    input  wire logic [15:0] i_data,
    input  wire logic [15:0] i_data_oe_n,
    input  wire logic        i_ack_n,
    input  wire logic        i_det1_n,
    input  wire logic        i_det2_n,
    // pins the host drives
    output logic             o_lo_en_n,
    output logic             o_hi_en_n,
    output logic [10:0]      o_addr,
    output logic             o_strobe_n,
    // what the host saw
    output logic             o_inserted,
    output logic [15:0]      o_bus,
    output logic [15:0]      o_got,
    output logic [15:0]      o_oe_got,
    output logic             o_ack_got,
    output logic             o_idle_ok
);
    logic [15:0] last_q;

    assign o_inserted = !i_det1_n && !i_det2_n;
    // released lanes float, shown as the inverse of the last value
    assign o_bus = (~i_data_oe_n & i_data) | (i_data_oe_n & ~last_q);
    always_ff @(posedge i_core_clk) begin
        last_q <= o_bus;
    end

    // idle pins at time zero
    initial begin
        o_lo_en_n = 1'b1;
        o_hi_en_n = 1'b1;
        o_addr = 11'h000;
        o_strobe_n = 1'b1;
    end

    // one strobed read of four cycles, then release
    task automatic read(input logic lo_n, input logic hi_n,
                        input logic [10:0] a);
        @(negedge i_core_clk);
        o_lo_en_n = lo_n;
        o_hi_en_n = hi_n;
        o_addr = a;
        o_strobe_n = 1'b0;
        repeat (4) @(negedge i_core_clk);
        o_got = o_bus;
        o_oe_got = i_data_oe_n;
        o_ack_got = !i_ack_n;
        o_strobe_n = 1'b1;
        o_lo_en_n = 1'b1;
        o_hi_en_n = 1'b1;
        @(negedge i_core_clk);
        o_idle_ok = &i_data_oe_n && i_ack_n;
    endtask
endmodule

// ==== verif/chb_host_port_asserts.sv ====
`timescale 1ns/1ns
// pin-level checks on the host port
module chb_host_port_asserts (
    input wire logic               i_core_clk,
    input wire logic               i_reset,
    input wire chb_pkg::chb_mode_e i_mode,
    input wire logic               i_low_byte_enable_n,
    input wire logic               i_high_byte_enable_n,
    input wire logic               i_io_read_strobe_n,
    input wire logic               o_req_valid,
    input wire logic [15:0]        o_data_oe_n,
    input wire logic               o_battery_detect_two,
    input wire logic               o_card_detect_one_n,
    input wire logic               o_card_detect_two_n,
    input wire logic               o_input_acknowledge_n,
    input wire logic               o_drive_active_slave_present_n,
    input wire logic               o_drive_active_slave_present_oe_n,
    input wire logic               o_is_master
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    // a selected strobe falling in a strobed mode
    sequence s_read_start;
        $fell(i_io_read_strobe_n) && i_mode != chb_pkg::CHB_MODE_MEM
            && !(i_low_byte_enable_n && i_high_byte_enable_n);
    endsequence
    // all sixteen lanes and ack let go
    sequence s_released;
        &o_data_oe_n && o_input_acknowledge_n;
    endsequence

    a_cd_grounded: assert property (
        !o_card_detect_one_n && !o_card_detect_two_n)
        else $error("card detect not low");
    a_bvd_mem_high: assert property (
        i_mode == chb_pkg::CHB_MODE_MEM && $past(i_mode) == i_mode
        |-> o_battery_detect_two)
        else $error("battery detect low in memory mode");
    a_audio_io_high: assert property (
        i_mode == chb_pkg::CHB_MODE_IO && $past(i_mode) == i_mode
        |-> o_battery_detect_two) else $error("audio low in io mode");
    a_mem_stays_quiet: assert property (
        i_mode == chb_pkg::CHB_MODE_MEM && $past(i_mode) == i_mode
        && $past(i_mode, 2) == i_mode |-> s_released)
        else $error("memory mode answered a strobe");
    a_ide_no_ack: assert property (
        i_mode == chb_pkg::CHB_MODE_IDE && $past(i_mode) == i_mode
        |-> o_input_acknowledge_n) else $error("ack in ide mode");
    a_req_follows: assert property (
        s_read_start |=> o_req_valid) else $error("read not taken");
    a_req_single: assert property (
        o_req_valid |=> !o_req_valid) else $error("request not a pulse");
    a_drive_gated: assert property (
        o_data_oe_n != 16'hffff |-> $past(i_io_read_strobe_n) == 1'b0)
        else $error("bus driven without strobe");
    a_release_after: assert property (
        $rose(i_io_read_strobe_n) |=> s_released)
        else $error("bus held after strobe");
    a_ack_gated: assert property (
        !o_input_acknowledge_n |-> $past(i_io_read_strobe_n) == 1'b0
        && $past(i_mode) == chb_pkg::CHB_MODE_IO)
        else $error("ack without io read");
    a_slave_drives_low: assert property (
        !o_is_master && !$past(o_is_master)
        && i_mode == chb_pkg::CHB_MODE_IDE && $past(i_mode) == i_mode
        && $past(i_mode, 2) == i_mode
        |-> !o_drive_active_slave_present_oe_n
        && !o_drive_active_slave_present_n)
        else $error("slave not driving present line");
endmodule

bind chb_host_port chb_host_port_asserts i_asserts (
    .i_core_clk, .i_reset, .i_mode, .i_low_byte_enable_n,
    .i_high_byte_enable_n, .i_io_read_strobe_n, .o_req_valid,
    .o_data_oe_n, .o_battery_detect_two, .o_card_detect_one_n,
    .o_card_detect_two_n, .o_input_acknowledge_n,
    .o_drive_active_slave_present_n, .o_drive_active_slave_present_oe_n,
    .o_is_master
);

// ==== verif/chb_host_port_test.sv ====
`timescale 1ns/1ns
// bench for the host port with a host model on the pins
module chb_host_port_test;
    logic               clk, rst, strap_n, rsp_v, rsp_rdy, req_v, bvd;
    logic               det1, det2, ack, pres_o, pres_oe, pres_w, is_m, peer;
    logic               lo_n, hi_n, stb_n, ins, ack_got, idle_ok;
    logic [10:0]        addr;
    logic [15:0]        dat, oe_n, bus, got, oe_got;
    chb_pkg::chb_mode_e mode;
    chb_pkg::chb_rsp_s  rsp;
    chb_pkg::chb_req_s  req;
    int                 fails, total_checks, cycles;

    // present line is pulled up when nobody drives it
    assign pres_w = pres_oe ? 1'b1 : pres_o;

    chb_host_port i_chb_host_port (
        .i_core_clk(clk), .i_reset(rst), .i_mode(mode),
        .i_cable_select_n(strap_n), .i_low_byte_enable_n(lo_n),
        .i_high_byte_enable_n(hi_n), .i_addr(addr),
        .i_io_read_strobe_n(stb_n), .o_req(req), .o_req_valid(req_v),
        .i_rsp(rsp), .i_rsp_valid(rsp_v), .o_rsp_ready(rsp_rdy),
        .o_data(dat), .o_data_oe_n(oe_n), .o_battery_detect_two(bvd),
        .o_card_detect_one_n(det1), .o_card_detect_two_n(det2),
        .o_input_acknowledge_n(ack),
        .i_drive_active_slave_present_n(pres_w),
        .o_drive_active_slave_present_n(pres_o),
        .o_drive_active_slave_present_oe_n(pres_oe),
        .o_is_master(is_m), .o_peer_present(peer));

    chb_host_model i_host (
        .i_core_clk(clk), .i_data(dat), .i_data_oe_n(oe_n), .i_ack_n(ack),
        .i_det1_n(det1), .i_det2_n(det2), .o_lo_en_n(lo_n), .o_hi_en_n(hi_n),
        .o_addr(addr), .o_strobe_n(stb_n), .o_inserted(ins), .o_bus(bus),
        .o_got(got), .o_oe_got(oe_got), .o_ack_got(ack_got),
        .o_idle_ok(idle_ok));

    // compare helpers
    task automatic chk_bit(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %0t bit got %b exp %b", $time, g, e);
        end
    endtask
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %0t word got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reset with a given strap, memory mode meanwhile
    task automatic do_reset(input logic cs);
        rst = 1'b1;
        strap_n = cs;
        mode = chb_pkg::CHB_MODE_MEM;
        repeat (16) @(negedge clk);
        rst = 1'b0;
    endtask
    // hand one word to the buffer
    task automatic push(input logic [15:0] w);
        rsp.data = w;
        rsp_v = 1'b1;
        @(negedge clk);
        rsp_v = 1'b0;
        // let an edge pass so back-to-back pushes never retoggle valid
        @(negedge clk);
    endtask

    task automatic t_status;
        repeat (3) @(negedge clk);
        chk_bit(bvd, 1'b1);
        chk_bit(ins, 1'b1);
        mode = chb_pkg::CHB_MODE_IO;
        repeat (3) @(negedge clk);
        chk_bit(bvd, 1'b1);
        chk_bit(is_m, 1'b0);
        mode = chb_pkg::CHB_MODE_MEM;
        i_host.read(1'b0, 1'b0, 11'h000);
        chk_word(oe_got, 16'hffff);
        chk_bit(ack_got, 1'b0);
        $display("test status done");
    endtask

    task automatic t_io_lanes;
        logic [15:0] w, m, e;
        mode = chb_pkg::CHB_MODE_IO;
        for (int k = 0; k < 4; k++) begin
            w = 16'hc3a5 ^ 16'(k * 257);
            m = (k == 0) ? 16'hffff : (k == 3) ? 16'hff00 : 16'h00ff;
            e = (k == 0) ? w : (k == 1) ? {8'h00, w[7:0]} :
                (k == 2) ? {8'h00, w[15:8]} : {w[15:8], 8'h00};
            push(w);
            i_host.read(k == 3, k == 1 || k == 2, 11'(k == 2));
            chk_word(got & m, e);
            chk_word(oe_got & m, 16'h0000);
            chk_bit(ack_got, 1'b1);
            chk_bit(idle_ok, 1'b1);
        end
        $display("test io lanes done");
    endtask

    task automatic t_buffer;
        push(16'h0f1e);
        push(16'h2d3c);
        chk_bit(rsp_rdy, 1'b0);
        i_host.read(1'b0, 1'b0, 11'h000);
        chk_bit(rsp_rdy, 1'b1);
        chk_word(got, 16'h2d3c);
        $display("test buffer done");
    endtask

    task automatic t_ide;
        do_reset(1'b0);
        mode = chb_pkg::CHB_MODE_IDE;
        repeat (3) @(negedge clk);
        chk_bit(is_m, 1'b1);
        push(16'h8e71);
        i_host.read(1'b0, 1'b1, 11'h000);
        chk_word(got, 16'h8e71);
        chk_bit(peer, 1'b0);
        chk_bit(req.task_file, 1'b1);
        chk_bit(ack_got, 1'b0);
        push(16'h4b96);
        i_host.read(1'b0, 1'b1, 11'h001);
        chk_word(got & 16'h00ff, 16'h0096);
        push(16'h5aa5);
        i_host.read(1'b1, 1'b0, 11'h006);
        chk_word(got & 16'h00ff, 16'h00a5);
        chk_bit(req.control_block, 1'b1);
        chk_bit(req.task_file, 1'b0);
        do_reset(1'b1);
        mode = chb_pkg::CHB_MODE_IDE;
        repeat (4) @(negedge clk);
        chk_bit(is_m, 1'b0);
        chk_bit(pres_oe, 1'b0);
        chk_bit(pres_o, 1'b0);
        $display("test ide done");
    endtask

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            results();
        end
    end
    // main sequence
    initial begin
        rsp_v = 1'b0;
        rsp.data = 16'h0000;
        do_reset(1'b0);
        t_status();
        t_io_lanes();
        t_buffer();
        t_ide();
        results();
    end
endmodule
